// ==== src/ufls_pkg.sv ====
/*
 ufls_pkg: constants, field layouts, reset values and types for the serial
 port fifo control, line format and line status block.
 Assumes a 200 MHz clk, APB register access with 16-bit byte addresses.
*/
package ufls_pkg;
   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_DATA = 14'h2510;
   localparam logic [13:0] IDX_DIVH = 14'h2511;
   localparam logic [13:0] IDX_FCR = 14'h2512;
   localparam logic [13:0] IDX_LCR = 14'h2513;
   localparam logic [13:0] IDX_LSR = 14'h2515;
   localparam logic [13:0] IDX_RIL = 14'h2518;
   // fifo control fields
   localparam int FCR_TRIG_LO = 6;
   localparam int FCR_TXFL = 2;
   localparam int FCR_RXFL = 1;
   // reset values
   localparam logic [1:0] TRIG_RST = 2'h3;
   localparam logic [7:0] LCR_RST = 8'h03;
   localparam logic [15:0] DIV_RST = 16'h0010;
   localparam logic [7:0] RIL_RST = 8'h00;
   // trigger thresholds for codes 0..3
   localparam logic [7:0] TRIG_T0 = 8'h01;
   localparam logic [7:0] TRIG_T1 = 8'h04;
   localparam logic [7:0] TRIG_T2 = 8'h08;
   localparam logic [7:0] TRIG_T3 = 8'h0e;
   // fifo geometry and indices into the fifo arrays
   localparam int DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int ENT_W = 11;
   localparam logic [4:0] FULL_CNT = 5'h10;
   localparam int TXF = 0;
   localparam int RXF = 1;
   localparam logic [5:0] TOUT_CHARS = 6'h04;

   typedef struct packed {
      logic divisor_latch_access;
      logic brk;
      logic stick;
      logic even;
      logic parity_enable;
      logic stop2;
      logic [1:0] len;
   } ufls_lcr_t;

   typedef struct packed {
      logic bi;
      logic fe;
      logic pe;
      logic [7:0] data;
   } ufls_ent_t;

   typedef enum logic [3:0] {
      S_NONE, S_DATA, S_DIVL, S_DIVH, S_FCR, S_LCR, S_LSR, S_RIL, S_BAD
   } ufls_sel_t;

   typedef enum logic [2:0] {
      TX_IDLE, TX_LOAD, TX_START, TX_DATA, TX_PAR, TX_STOP
   } ufls_tx_st_t;

   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK
   } ufls_rx_st_t;
endpackage : ufls_pkg

// ==== src/ufls_mem.sv ====
/*
 ufls_mem: small fifo storage array with a registered read port.
 Assumes the caller keeps pointers; a write to the address being read
 is passed straight to the read register.
*/
`timescale 1ns/1ps
module ufls_mem #(
   parameter int W = 11,
   parameter int D = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata_r
);
   logic [W-1:0] mem [D];

   // storage, no reset needed
   always_ff @(posedge clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   // bypass keeps the head valid right after a push into an empty fifo
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r <= '0;
      end else if (ce) begin
         rdata_r <= (we && waddr == raddr) ? wdata : mem[raddr];
      end
   end
endmodule : ufls_mem

// ==== src/ufls_top.sv ====
/*
 ufls_top: fifo control, line format and line status of a serial port,
 with transmitter, receiver, two 16-entry fifos and an APB slave.
 Assumes rx_pin is asynchronous; pready inserts one wait state.
*/
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module ufls_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_pin,
   output logic tx_pin,
   output logic rx_data_irq,
   output logic tx_empty_irq,
   output logic line_status_irq,
   output logic rx_timeout_irq
);
   ufls_pkg::ufls_lcr_t lcr_r;
   ufls_pkg::ufls_sel_t sel;
   ufls_pkg::ufls_tx_st_t tx_st;
   ufls_pkg::ufls_rx_st_t rx_st;
   ufls_pkg::ufls_ent_t head, rx_ent;
   logic [1:0] trig_r;
   logic [15:0] div_r;
   logic [7:0] ril_r, thr, lsr_v, rmux;
   logic ack_r, done, wr, rd;
   logic [ufls_pkg::PTR_W-1:0] wp [2];
   logic [ufls_pkg::PTR_W-1:0] rp [2];
   logic [4:0] cnt [2];
   logic [1:0] push, pop, fl;
   logic [ufls_pkg::ENT_W-1:0] wdat [2];
   logic [ufls_pkg::ENT_W-1:0] rdat [2];
   logic [16:0] bit_clks, half_clks, stop_clks, tx_tmr, rx_tmr;
   logic [3:0] clen;
   logic [7:0] tx_sh, rx_sh;
   logic [2:0] tx_bitn, rx_bitn;
   logic tx_par, line_nxt;
   logic rx_s1, rx_s2, rx_q, rx_zero, rx_pbit, rx_done, rx_brk;
   logic oe_r, rx_error_any_r, seen_r;
   logic [21:0] tout_r, tout_lim;
   logic [5:0] char_bits;

   // data bits per character from the length code
   function automatic logic [3:0] char_len_f(input logic [1:0] len);
      return 4'h5 + {2'h0, len};
   endfunction : char_len_f

   // parity bit for a character, shared by sender and checker
   function automatic logic par_f(input logic [7:0] d, input ufls_pkg::ufls_lcr_t l);
      logic [7:0] m;
      m = 8'hff >> (4'h8 - char_len_f(l.len));
      return l.stick ? ~l.even : (^(d & m)) ^ ~l.even;
   endfunction : par_f

   // register decode; the shared index moves with the latch access bit
   always_comb begin
      case (paddr[15:2])
         ufls_pkg::IDX_DATA: sel = lcr_r.divisor_latch_access ? ufls_pkg::S_DIVL : ufls_pkg::S_DATA;
         ufls_pkg::IDX_DIVH: sel = lcr_r.divisor_latch_access ? ufls_pkg::S_DIVH : ufls_pkg::S_NONE;
         ufls_pkg::IDX_FCR: sel = ufls_pkg::S_FCR;
         ufls_pkg::IDX_LCR: sel = ufls_pkg::S_LCR;
         ufls_pkg::IDX_LSR: sel = ufls_pkg::S_LSR;
         ufls_pkg::IDX_RIL: sel = ufls_pkg::S_RIL;
         default: sel = ufls_pkg::S_BAD;
      endcase
   end

   // apb handshake: one wait state so read data comes from a flop
   assign pready = psel & penable & ack_r & ce;
   assign pslverr = pready & (sel == ufls_pkg::S_BAD);
   assign done = pready;
   assign wr = done & pwrite;
   assign rd = done & ~pwrite;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else if (ce) begin
         ack_r <= psel & penable & ~ack_r;
      end
   end

   // read mux, captured in the first access cycle
   always_comb begin
      case (sel)
         ufls_pkg::S_DATA: rmux = head.data;
         ufls_pkg::S_DIVL: rmux = div_r[7:0];
         ufls_pkg::S_DIVH: rmux = div_r[15:8];
         ufls_pkg::S_LCR: rmux = lcr_r;
         ufls_pkg::S_LSR: rmux = lsr_v;
         ufls_pkg::S_RIL: rmux = ril_r;
         default: rmux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0;
      end else if (ce && psel && penable && !ack_r && !pwrite) begin
         prdata <= {24'h0, rmux};
      end
   end

   // software written control registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lcr_r <= ufls_pkg::LCR_RST;
         trig_r <= ufls_pkg::TRIG_RST;
         div_r <= ufls_pkg::DIV_RST;
         ril_r <= ufls_pkg::RIL_RST;
      end else if (wr) begin
         case (sel)
            ufls_pkg::S_LCR: lcr_r <= pwdata[7:0];
            ufls_pkg::S_FCR: trig_r <= pwdata[ufls_pkg::FCR_TRIG_LO +: 2];
            ufls_pkg::S_DIVL: div_r[7:0] <= pwdata[7:0];
            ufls_pkg::S_DIVH: div_r[15:8] <= pwdata[7:0];
            ufls_pkg::S_RIL: ril_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // flush bits are never stored, only pulsed
   assign fl[ufls_pkg::TXF] = wr & (sel == ufls_pkg::S_FCR) & pwdata[ufls_pkg::FCR_TXFL];
   assign fl[ufls_pkg::RXF] = wr & (sel == ufls_pkg::S_FCR) & pwdata[ufls_pkg::FCR_RXFL];
   assign push[ufls_pkg::TXF] = wr & (sel == ufls_pkg::S_DATA) & (cnt[ufls_pkg::TXF] != ufls_pkg::FULL_CNT);
   assign pop[ufls_pkg::TXF] = ce & (tx_st == ufls_pkg::TX_LOAD);
   assign wdat[ufls_pkg::TXF] = {3'h0, pwdata[7:0]};
   assign rx_done = ce & (rx_st == ufls_pkg::RX_STOP) & (rx_tmr == 17'h0);
   assign push[ufls_pkg::RXF] = rx_done & (cnt[ufls_pkg::RXF] != ufls_pkg::FULL_CNT);
   assign pop[ufls_pkg::RXF] = rd & (sel == ufls_pkg::S_DATA) & (cnt[ufls_pkg::RXF] != 5'h0);
   assign wdat[ufls_pkg::RXF] = rx_ent;
   assign head = rdat[ufls_pkg::RXF];

   // both fifos share one pointer scheme
   for (genvar g = 0; g < 2; g++) begin : g_fifo
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            wp[g] <= '0;
            rp[g] <= '0;
            cnt[g] <= 5'h0;
         end else if (ce) begin
            if (fl[g]) begin
               wp[g] <= '0;
               rp[g] <= '0;
               cnt[g] <= 5'h0;
            end else begin
               wp[g] <= wp[g] + ufls_pkg::PTR_W'(push[g]);
               rp[g] <= rp[g] + ufls_pkg::PTR_W'(pop[g]);
               cnt[g] <= cnt[g] + {4'h0, push[g]} - {4'h0, pop[g]};
            end
         end
      end

      ufls_mem #(.W(ufls_pkg::ENT_W), .D(ufls_pkg::DEPTH), .AW(ufls_pkg::PTR_W)) u_mem (
         .clk(clk),
         .rst(rst),
         .ce(ce),
         .we(push[g] & ~fl[g]),
         .waddr(wp[g]),
         .wdata(wdat[g]),
         .raddr(rp[g]),
         .rdata_r(rdat[g])
      );
   end

   // bit timing from the divisor; zero divisor treated as one
   assign bit_clks = (div_r == 16'h0) ? 17'h1 : {1'b0, div_r};
   assign half_clks = bit_clks >> 1;
   assign clen = char_len_f(lcr_r.len);
   assign stop_clks = !lcr_r.stop2 ? bit_clks :
      (lcr_r.len == 2'h0) ? bit_clks + half_clks : bit_clks << 1;

   // transmitter sequence
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_st <= ufls_pkg::TX_IDLE;
         tx_tmr <= 17'h0;
         tx_sh <= 8'h0;
         tx_bitn <= 3'h0;
         tx_par <= 1'b0;
      end else if (ce) begin
         if (fl[ufls_pkg::TXF]) begin
            tx_st <= ufls_pkg::TX_IDLE;
         end else if (tx_st != ufls_pkg::TX_IDLE && tx_st != ufls_pkg::TX_LOAD && tx_tmr != 17'h0) begin
            tx_tmr <= tx_tmr - 17'h1;
         end else begin
            case (tx_st)
               ufls_pkg::TX_IDLE: if (cnt[ufls_pkg::TXF] != 5'h0) tx_st <= ufls_pkg::TX_LOAD;
               ufls_pkg::TX_LOAD: begin
                  tx_sh <= rdat[ufls_pkg::TXF][7:0];
                  tx_par <= par_f(rdat[ufls_pkg::TXF][7:0], lcr_r);
                  tx_tmr <= bit_clks - 17'h1;
                  tx_st <= ufls_pkg::TX_START;
               end
               ufls_pkg::TX_START: begin
                  tx_bitn <= 3'h0;
                  tx_tmr <= bit_clks - 17'h1;
                  tx_st <= ufls_pkg::TX_DATA;
               end
               ufls_pkg::TX_DATA: begin
                  tx_sh <= tx_sh >> 1;
                  tx_bitn <= tx_bitn + 3'h1;
                  if ({1'b0, tx_bitn} == clen - 4'h1) begin
                     tx_st <= lcr_r.parity_enable ? ufls_pkg::TX_PAR : ufls_pkg::TX_STOP;
                     tx_tmr <= lcr_r.parity_enable ? bit_clks - 17'h1 : stop_clks - 17'h1;
                  end else begin
                     tx_tmr <= bit_clks - 17'h1;
                  end
               end
               ufls_pkg::TX_PAR: begin
                  tx_tmr <= stop_clks - 17'h1;
                  tx_st <= ufls_pkg::TX_STOP;
               end
               ufls_pkg::TX_STOP: tx_st <= ufls_pkg::TX_IDLE;
               default: tx_st <= ufls_pkg::TX_IDLE;
            endcase
         end
      end
   end

   always_comb begin
      case (tx_st)
         ufls_pkg::TX_START: line_nxt = 1'b0;
         ufls_pkg::TX_DATA: line_nxt = tx_sh[0];
         ufls_pkg::TX_PAR: line_nxt = tx_par;
         default: line_nxt = 1'b1;
      endcase
   end

   // line register; break overrides whatever the sequencer shows
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_pin <= 1'b1;
      end else if (ce) begin
         tx_pin <= lcr_r.brk ? 1'b0 : line_nxt;
      end
   end

   // receive pin synchroniser; rx_s1 feeds only rx_s2
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_q <= 1'b1;
      end else if (ce) begin
         rx_s1 <= rx_pin;
         rx_s2 <= rx_s1;
         rx_q <= rx_s2;
      end
   end

   // character assembled at the stop sample; break wins over its contents
   assign rx_brk = rx_zero & ~rx_s2;
   always_comb begin
      rx_ent.data = rx_brk ? 8'h00 : rx_sh >> (4'h8 - clen);
      rx_ent.bi = rx_brk;
      rx_ent.fe = ~rx_s2;
      rx_ent.pe = ~rx_brk & lcr_r.parity_enable & (rx_pbit != par_f(rx_ent.data, lcr_r));
   end

   // receiver sequence, samples at mid-bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_st <= ufls_pkg::RX_IDLE;
         rx_tmr <= 17'h0;
         rx_sh <= 8'h0;
         rx_bitn <= 3'h0;
         rx_zero <= 1'b0;
         rx_pbit <= 1'b0;
      end else if (ce) begin
         if (rx_st != ufls_pkg::RX_IDLE && rx_st != ufls_pkg::RX_BRK && rx_tmr != 17'h0) begin
            rx_tmr <= rx_tmr - 17'h1;
         end else begin
            case (rx_st)
               ufls_pkg::RX_IDLE: if (rx_q && !rx_s2) begin
                  rx_tmr <= half_clks;
                  rx_st <= ufls_pkg::RX_START;
               end
               ufls_pkg::RX_START: begin
                  rx_bitn <= 3'h0;
                  rx_zero <= 1'b1;
                  rx_tmr <= bit_clks - 17'h1;
                  rx_st <= rx_s2 ? ufls_pkg::RX_IDLE : ufls_pkg::RX_DATA; // glitch rejected
               end
               ufls_pkg::RX_DATA: begin
                  rx_sh <= {rx_s2, rx_sh[7:1]};
                  rx_zero <= rx_zero & ~rx_s2;
                  rx_bitn <= rx_bitn + 3'h1;
                  rx_tmr <= bit_clks - 17'h1;
                  if ({1'b0, rx_bitn} == clen - 4'h1) begin
                     rx_st <= lcr_r.parity_enable ? ufls_pkg::RX_PAR : ufls_pkg::RX_STOP;
                  end
               end
               ufls_pkg::RX_PAR: begin
                  rx_pbit <= rx_s2;
                  rx_zero <= rx_zero & ~rx_s2;
                  rx_tmr <= bit_clks - 17'h1;
                  rx_st <= ufls_pkg::RX_STOP;
               end
               ufls_pkg::RX_STOP: rx_st <= rx_brk ? ufls_pkg::RX_BRK : ufls_pkg::RX_IDLE;
               ufls_pkg::RX_BRK: if (rx_s2) rx_st <= ufls_pkg::RX_IDLE;
               default: rx_st <= ufls_pkg::RX_IDLE;
            endcase
         end
      end
   end

   // line status view; head flags hide once a status read has shown them
   always_comb begin
      lsr_v[0] = cnt[ufls_pkg::RXF] != 5'h0;
      lsr_v[1] = oe_r;
      lsr_v[2] = lsr_v[0] & ~seen_r & head.pe;
      lsr_v[3] = lsr_v[0] & ~seen_r & head.fe;
      lsr_v[4] = lsr_v[0] & ~seen_r & head.bi;
      lsr_v[5] = cnt[ufls_pkg::TXF] == 5'h0;
      lsr_v[6] = lsr_v[5] & (tx_st == ufls_pkg::TX_IDLE);
      lsr_v[7] = rx_error_any_r;
   end

   // sticky status; only bits the read returned are cleared, a new set wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oe_r <= 1'b0;
         rx_error_any_r <= 1'b0;
         seen_r <= 1'b0;
      end else if (ce) begin
         if (rx_done && !push[ufls_pkg::RXF]) begin
            oe_r <= 1'b1;
         end else if (rd && sel == ufls_pkg::S_LSR && prdata[1]) begin
            oe_r <= 1'b0;
         end
         if (push[ufls_pkg::RXF] && (rx_ent.pe || rx_ent.fe || rx_ent.bi)) begin
            rx_error_any_r <= 1'b1;
         end else if (fl[ufls_pkg::RXF] || (rd && sel == ufls_pkg::S_LSR && prdata[7])) begin
            rx_error_any_r <= 1'b0;
         end
         if (pop[ufls_pkg::RXF] || fl[ufls_pkg::RXF]) begin
            seen_r <= 1'b0;
         end else if (rd && sel == ufls_pkg::S_LSR && |prdata[4:2]) begin
            seen_r <= 1'b1;
         end
      end
   end

   // receive threshold: a nonzero level register overrides the two-bit code
   always_comb begin
      case (trig_r)
         2'h0: thr = ufls_pkg::TRIG_T0;
         2'h1: thr = ufls_pkg::TRIG_T1;
         2'h2: thr = ufls_pkg::TRIG_T2;
         default: thr = ufls_pkg::TRIG_T3;
      endcase
      if (ril_r != 8'h00) begin
         thr = ril_r;
      end
   end

   // timeout limit is four whole character times in clocks
   assign char_bits = 6'h1 + {2'h0, clen} + {5'h0, lcr_r.parity_enable} + (lcr_r.stop2 ? 6'h2 : 6'h1);
   // widened first so the clock count cannot wrap in the 17 bits of bit_clks
   assign tout_lim = 22'(bit_clks) * 22'(char_bits) * 22'(ufls_pkg::TOUT_CHARS);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tout_r <= 22'h0;
      end else if (ce) begin
         if (lsr_v[0] == 1'b0 || push[ufls_pkg::RXF] || pop[ufls_pkg::RXF]) begin
            tout_r <= 22'h0;
         end else if (tout_r < tout_lim) begin
            tout_r <= tout_r + 22'h1;
         end
      end
   end

   // registered indications for the interrupt controller
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_data_irq <= 1'b0;
         tx_empty_irq <= 1'b1;
         line_status_irq <= 1'b0;
         rx_timeout_irq <= 1'b0;
      end else if (ce) begin
         rx_data_irq <= {3'h0, cnt[ufls_pkg::RXF]} >= thr;
         tx_empty_irq <= lsr_v[5];
         line_status_irq <= |lsr_v[4:1];
         rx_timeout_irq <= lsr_v[0] && tout_r >= tout_lim;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_break_line_low: assert property (ce && lcr_r.brk |=> !tx_pin)
      else $error("break does not hold line low");
   a_tx_flush_empty: assert property (fl[0] |=> cnt[0] == 5'h0 && lsr_v[5])
      else $error("transmit flush left data");
   a_rx_flush_empty: assert property (fl[1] |=> !lsr_v[0])
      else $error("receive flush left data");
   a_trig_below: assert property (ce && trig_r == 2'h3 && ril_r == 8'h00 && cnt[1] == 5'h0d |=> !rx_data_irq)
      else $error("receive interrupt below fourteen");
   a_trig_reach: assert property (ce && trig_r == 2'h3 && ril_r == 8'h00 && cnt[1] == 5'h0e |=> rx_data_irq)
      else $error("receive interrupt missing at fourteen");
   a_data_ready_push: assert property (push[1] && !fl[1] |=> lsr_v[0])
      else $error("data ready not set after receive");
   a_overrun_full: assert property (rx_done && cnt[1] == ufls_pkg::FULL_CNT |=> oe_r && $stable(cnt[1]))
      else $error("overrun not flagged or fifo changed");
   a_tx_all_idle_tx_fifo_empty_pair: assert property (lsr_v[6] |-> lsr_v[5] && tx_st == ufls_pkg::TX_IDLE)
      else $error("transmitter empty without idle fifo");
   a_tx_fifo_empty_write: assert property (push[0] && !fl[0] |=> !lsr_v[5] && !lsr_v[6])
      else $error("empty flags not cleared by write");
   a_stick_parity: assert property (ce && tx_st == ufls_pkg::TX_PAR && lcr_r.parity_enable && lcr_r.stick
      && !lcr_r.brk && $stable(lcr_r) |=> tx_pin == !$past(lcr_r.even))
      else $error("stick parity bit wrong");
   a_break_waits: assert property (rx_done && rx_brk |=> rx_st == ufls_pkg::RX_BRK)
      else $error("break did not wait for idle line");

   c_rx_char: cover property (push[1] && !rx_ent.pe && !rx_ent.fe);
   c_tx_char: cover property (tx_st == ufls_pkg::TX_STOP ##1 tx_st == ufls_pkg::TX_IDLE);
   c_overrun: cover property (rx_done && !push[1]);
   c_timeout: cover property ($rose(rx_timeout_irq));
endmodule : ufls_top

// ==== verification/ufls_remote.sv ====
/*
 ufls_remote: far-end serial device, sends frames on the receive line
 and captures frames from the transmit line.
 Assumes the block's bit time equals BIT clocks of clk.
*/
`timescale 1ns/1ps
module ufls_remote #(
   parameter int BIT = 8
) (
   input wire logic clk,
   input wire logic tx_pin,
   output logic rx_pin
);
   initial rx_pin = 1'b1; // line idles high
   // start low, data lsb first, optional parity, stop high
   task automatic send(input logic [7:0] d, input logic usep, input logic p);
      int i;
      rx_pin <= 1'b0;
      repeat (BIT) @(posedge clk);
      for (i = 0; i < 8 + usep; i++) begin
         rx_pin <= (i < 8) ? d[i] : p;
         repeat (BIT) @(posedge clk);
      end
      rx_pin <= 1'b1;
      repeat (2 * BIT) @(posedge clk);
   endtask : send
   // line held low longer than a whole character
   task automatic brk;
      rx_pin <= 1'b0;
      repeat (12 * BIT) @(posedge clk);
      rx_pin <= 1'b1;
      repeat (2 * BIT) @(posedge clk);
   endtask : brk
   // bounded wait for a start bit, then mid-bit sampling
   task automatic recv(output logic [7:0] d, output logic ok);
      int i;
      ok = 1'b0;
      d = 8'h00;
      for (i = 0; i < 400 && tx_pin; i++) @(posedge clk);
      if (tx_pin === 1'b0) begin
         repeat (BIT / 2) @(posedge clk);
         for (i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            d[i] = tx_pin;
         end
         repeat (BIT) @(posedge clk);
         ok = tx_pin;
      end
   endtask : recv
endmodule : ufls_remote

// ==== verification/ufls_top_tb.sv ====
/*
 ufls_top_tb: register-level tests of line format and line status.
 Assumes the remote model on the serial pins and divisor 8.
*/
`timescale 1ns/1ps
module ufls_top_tb;
   logic clk, rst, ce, psel, penable, pwrite, pready, pslverr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic rx_pin, tx_pin, rx_data_irq, tx_empty_irq, line_status_irq, rx_timeout_irq;
   logic [7:0] d;
   logic ok, e;
   logic [31:0] r;
   int err_total = 0;
   int cmp_count = 0;
   ufls_top dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_data_irq(rx_data_irq), .tx_empty_irq(tx_empty_irq),
      .line_status_irq(line_status_irq), .rx_timeout_irq(rx_timeout_irq));
   ufls_remote #(.BIT(8)) rem (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_pin));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task conclude;
      if (err_total == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one transfer; pready, data and error taken at the same rising edge
   task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] wd);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         chk(32'h0, 32'h1);
         conclude();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [13:0] idx, input logic [7:0] wd);
      apb(1'b1, idx, wd);
   endtask : wr
   task automatic rc(input logic [13:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(r, {24'h0, exp});
   endtask : rc
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rc(ufls_pkg::IDX_LCR, 8'h03);
      rc(ufls_pkg::IDX_LSR, 8'h60);
      chk({31'h0, tx_empty_irq}, 32'h1);
      apb(1'b0, 14'h2600, 8'h00);
      chk({31'h0, e}, 32'h1);
      wr(ufls_pkg::IDX_LCR, 8'h83);
      wr(ufls_pkg::IDX_DATA, 8'h08);
      wr(ufls_pkg::IDX_DIVH, 8'h00);
      rc(ufls_pkg::IDX_DATA, 8'h08);
      wr(ufls_pkg::IDX_LCR, 8'h03);
      // transmit one character and catch it at the far end
      fork
         wr(ufls_pkg::IDX_DATA, 8'ha5);
         rem.recv(d, ok);
      join
      chk({24'h0, d}, 32'ha5);
      chk({31'h0, ok}, 32'h1);
      repeat (24) @(posedge clk);
      rc(ufls_pkg::IDX_LSR, 8'h60);
      rem.send(8'h3c, 1'b0, 1'b0);
      rc(ufls_pkg::IDX_LSR, 8'h61);
      repeat (330) @(posedge clk);
      chk({31'h0, rx_timeout_irq}, 32'h1);
      rc(ufls_pkg::IDX_DATA, 8'h3c);
      rc(ufls_pkg::IDX_LSR, 8'h60);
      // odd parity wanted, zero sent: error shown once
      wr(ufls_pkg::IDX_LCR, 8'h0b);
      rem.send(8'h3c, 1'b1, 1'b0);
      rc(ufls_pkg::IDX_LSR, 8'he5);
      rc(ufls_pkg::IDX_LSR, 8'h61);
      rc(ufls_pkg::IDX_DATA, 8'h3c);
      wr(ufls_pkg::IDX_LCR, 8'h3b);
      rem.send(8'h3c, 1'b1, 1'b0);
      rc(ufls_pkg::IDX_LSR, 8'h61);
      rc(ufls_pkg::IDX_DATA, 8'h3c);
      // stick parity on the sending side too
      fork
         wr(ufls_pkg::IDX_DATA, 8'h3c);
         rem.recv(d, ok);
      join
      chk({24'h0, d}, 32'h3c);
      repeat (24) @(posedge clk);
      wr(ufls_pkg::IDX_LCR, 8'h03);
      rem.brk();
      chk({31'h0, line_status_irq}, 32'h1);
      rc(ufls_pkg::IDX_LSR, 8'hf9);
      rc(ufls_pkg::IDX_DATA, 8'h00);
      // flush drops the character; self-clearing lets the next one in
      rem.send(8'h55, 1'b0, 1'b0);
      wr(ufls_pkg::IDX_FCR, 8'h02);
      rc(ufls_pkg::IDX_LSR, 8'h60);
      wr(ufls_pkg::IDX_FCR, 8'h00);
      rem.send(8'h5a, 1'b0, 1'b0);
      chk({31'h0, rx_data_irq}, 32'h1);
      rc(ufls_pkg::IDX_DATA, 8'h5a);
      // transmit flush aborts a character in flight
      wr(ufls_pkg::IDX_DATA, 8'h11);
      wr(ufls_pkg::IDX_FCR, 8'h04);
      rc(ufls_pkg::IDX_LSR, 8'h60);
      wr(ufls_pkg::IDX_LCR, 8'h43);
      @(negedge clk);
      chk({31'h0, tx_pin}, 32'h0);
      wr(ufls_pkg::IDX_LCR, 8'h03);
      conclude();
   end
endmodule : ufls_top_tb
